//--- core/adc_pin_ctrl.sv
// pin-level control of an eight-channel simultaneous-sampling 14-bit converter
// assumes host pins are asynchronous; analog results arrive as codes on i_ch_code
// Behaviour
// [R1] results are 14-bit two's complement, all channels
// [R2] one code step is span over 16384
// [R3] step weight 1220.72 or 610.36 microvolts
// [R4] reference select high uses internal reference
// [R5] reference select acts asynchronously, at once; code registers it, taking effect one clock later
// [R6] span select picks ten or five volts
// [R7] host waits 80 us after span change
// [R8] low power request low enters standby/shutdown
// [R9] shutdown powers all down, standby keeps reference
// [R10] host waits recovery time after leaving power-down
// [R11] interface and byte select choose read mode
// [R12] low trigger samples 1-4, high 5-8
// [R13] oversampling needs both triggers joined
// [R14] trigger rise holds group, converts internally
// [R15] host drops triggers after busy falls
// [R16] reads allowed at any trigger level
// [R17] reset active high, asynchronous; code passes it through its own synchroniser and acts on it on the clock
// [R18] host resets after power-up and shutdown
// [R19] reset aborts conversion, clears output data
// [R20] host waits after reset before triggering
// [R21] parallel bus enabled while cs and strobe low
// [R22] serial accesses timed on serial clock rise
// [R23] busy from both triggers until latched, ignore
// [R24] cs fall starts frame, rise tristates outputs
// [R25] results held until next conversion or reset
`timescale 1ns/1ps
`default_nettype none
module adc_pin_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_reset,
    input wire logic i_reference_select,
    input wire logic i_input_span_select,
    input wire logic i_low_power_request_n,
    input wire logic i_interface_select,
    input wire logic i_byte_serial_select,
    input wire logic i_sample_trigger_lo_group,
    input wire logic i_sample_trigger_hi_group,
    input wire logic i_cs_n,
    input wire logic i_read_strobe_or_serial_clock,
    input wire logic [adc_pin_pkg::NUM_CH*adc_pin_pkg::RESULT_W-1:0] i_ch_code,
    output logic o_busy,
    output logic o_hold_lo,
    output logic o_hold_hi,
    output logic o_internal_ref_en,
    output logic o_reference_pin_oe,
    output logic o_wide_span,
    output logic [1:0] o_power_mode,
    output logic [1:0] o_iface_mode,
    output logic [15:0] o_data,
    output logic o_data_oe,
    output logic o_serial_a,
    output logic o_serial_b,
    output logic o_serial_oe
);
    localparam int unsigned RW = adc_pin_pkg::RESULT_W;
    localparam int unsigned NCH = adc_pin_pkg::NUM_CH;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic pins_d;
        adc_pin_pkg::pins_s prev;
        logic seen_lo;
        logic seen_hi;
        logic busy;
        logic conv_run;
        logic [7:0] conv_cnt;
        logic [NCH*RW-1:0] sample;
        logic [NCH*RW-1:0] result;
        logic [3:0] word_idx;
        logic byte_hi;
        logic [3:0] bit_idx;
        logic [15:0] data;
        logic data_oe;
        logic ser_a;
        logic ser_b;
        logic ser_oe;
        logic ref_en;
        logic ref_oe;
        logic wide;
        logic [1:0] pwr;
        logic [1:0] ifm;
    } state_s;
    state_s st_ff;
    state_s nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // synchronise host pins; the device reset pin also goes through its own sync
    logic [3:0] pin_raw;
    logic [3:0] pin_q;
    adc_pin_pkg::pins_s pins;
    logic rst_raw;
    logic [0:0] rst_q;

    // select and strobe idle high: they pass the sync inverted, so its cleared flops read
    // as idle and no false select or strobe edge follows reset
    assign pin_raw = {!i_cs_n, !i_read_strobe_or_serial_clock, i_sample_trigger_lo_group,
                      i_sample_trigger_hi_group};
    assign rst_raw = i_reset;

    adc_pin_sync #(.W(4)) u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(pin_raw),
        .o_sync(pin_q)
    );
    adc_pin_sync #(.W(1)) u_rst_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(rst_raw),
        .o_sync(rst_q)
    );
    assign pins = adc_pin_pkg::pins_s'(pin_q ^ 4'hc);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [RW-1:0] pick_word(input logic [NCH*RW-1:0] v, input logic [3:0] idx);
        logic [RW-1:0] w;
        w = '0;
        for (int i = 0; i < int'(NCH); i++) begin
            if (idx == 4'(i)) begin
                w = v[i*RW +: RW];
            end
        end
        return w;
    endfunction : pick_word

    // sign-extend a 14-bit two's complement code onto the 16-bit bus
    function automatic logic [15:0] sext(input logic [RW-1:0] c);
        return {{(16-RW){c[RW-1]}}, c};
    endfunction : sext

    ////////////////////////////////////////////////////////////////////////////
    // next state
    logic rise_lo;
    logic rise_hi;
    logic cs_fall;
    logic cs_rise;
    logic rd_fall;
    logic sclk_rise;
    logic dev_reset;
    logic [RW-1:0] cur_word;
    logic [15:0] cur_ext;
    logic [RW-1:0] next_a;
    logic [RW-1:0] next_b;
    logic [RW-1:0] cur_b;

    always_comb begin
        nxt_st = st_ff;
        dev_reset = rst_q[0];
        rise_lo = pins.trig_lo && !st_ff.prev.trig_lo;
        rise_hi = pins.trig_hi && !st_ff.prev.trig_hi;
        cs_fall = !pins.cs_n && st_ff.prev.cs_n;
        cs_rise = pins.cs_n && !st_ff.prev.cs_n;
        rd_fall = !pins.rd_sclk && st_ff.prev.rd_sclk;
        sclk_rise = pins.rd_sclk && !st_ff.prev.rd_sclk;
        cur_word = pick_word(st_ff.result, st_ff.word_idx);
        cur_ext = sext(cur_word);
        // words the serial lanes need: next channel on each lane, current one on lane b
        next_a = pick_word(st_ff.result, st_ff.word_idx + 4'h1);
        next_b = pick_word(st_ff.result, st_ff.word_idx + 4'h5);
        cur_b = pick_word(st_ff.result, st_ff.word_idx + 4'h4);
        nxt_st.prev = pins;

        // static pin-level configuration follows the pins directly
        nxt_st.ref_en = i_reference_select;              // R4 R5
        nxt_st.ref_oe = i_reference_select;              // R5
        nxt_st.wide = i_input_span_select;               // R6 R2 R3
        if (i_low_power_request_n) begin
            nxt_st.pwr = adc_pin_pkg::PWR_NORMAL;        // R8
        end else if (i_input_span_select) begin
            nxt_st.pwr = adc_pin_pkg::PWR_SHUTDOWN;      // R9
        end else begin
            nxt_st.pwr = adc_pin_pkg::PWR_STANDBY;       // R9
        end
        if (!i_interface_select) begin
            nxt_st.ifm = adc_pin_pkg::IF_PARALLEL;       // R11
        end else if (i_byte_serial_select) begin
            nxt_st.ifm = adc_pin_pkg::IF_BYTE;           // R11
        end else begin
            nxt_st.ifm = adc_pin_pkg::IF_SERIAL;         // R11
        end

        // conversion: groups hold on trigger rise, busy once both groups held
        if (!st_ff.busy && !st_ff.conv_run && st_ff.pwr == adc_pin_pkg::PWR_NORMAL) begin
            if (rise_lo && !st_ff.seen_lo) begin
                nxt_st.seen_lo = 1'b1;                   // R12 R14
                nxt_st.sample[0 +: 4*RW] = i_ch_code[0 +: 4*RW];
            end
            if (rise_hi && !st_ff.seen_hi) begin
                nxt_st.seen_hi = 1'b1;                   // R12 R14
                nxt_st.sample[4*RW +: 4*RW] = i_ch_code[4*RW +: 4*RW];
            end
            if ((st_ff.seen_lo || rise_lo) && (st_ff.seen_hi || rise_hi)) begin
                nxt_st.busy = 1'b1;                      // R23
                nxt_st.conv_run = 1'b1;
                nxt_st.conv_cnt = adc_pin_pkg::CONV_CNT_INIT;
            end
        end
        if (st_ff.conv_run) begin
            // triggers are ignored here while busy
            if (st_ff.conv_cnt == 8'(adc_pin_pkg::CONV_CYCLES - 1)) begin
                nxt_st.conv_run = 1'b0;
                nxt_st.busy = 1'b0;                      // R23
                nxt_st.seen_lo = 1'b0;
                nxt_st.seen_hi = 1'b0;
                nxt_st.result = st_ff.sample;            // R1 R25
            end else begin
                nxt_st.conv_cnt = st_ff.conv_cnt + 8'h01;
            end
        end

        // read side works at any trigger level
        if (cs_fall) begin
            nxt_st.word_idx = 4'h0;                      // R24
            nxt_st.byte_hi = 1'b0;
            nxt_st.bit_idx = 4'(RW - 1);
            if (st_ff.ifm == adc_pin_pkg::IF_SERIAL) begin
                nxt_st.ser_oe = 1'b1;
                nxt_st.ser_a = st_ff.result[RW-1];
                nxt_st.ser_b = st_ff.result[4*RW + RW-1];
            end
        end
        if (cs_rise) begin
            nxt_st.data_oe = 1'b0;                       // R24
            nxt_st.ser_oe = 1'b0;                        // R24
        end
        if (st_ff.ifm != adc_pin_pkg::IF_SERIAL) begin
            // parallel bus drives only while chip select and strobe are both low
            nxt_st.data_oe = !pins.cs_n && !pins.rd_sclk; // R21 R16
            nxt_st.ser_oe = 1'b0;
            if (!pins.cs_n && rd_fall) begin
                if (st_ff.ifm == adc_pin_pkg::IF_PARALLEL) begin
                    nxt_st.data = sext(cur_word);
                    nxt_st.word_idx = st_ff.word_idx + 4'h1;
                end else begin
                    nxt_st.data = st_ff.byte_hi ? {8'h00, cur_ext[15:8]} : {8'h00, cur_ext[7:0]};
                    nxt_st.byte_hi = !st_ff.byte_hi;
                    if (st_ff.byte_hi) begin
                        nxt_st.word_idx = st_ff.word_idx + 4'h1;
                    end
                end
            end
        end else begin
            nxt_st.data_oe = 1'b0;
            // serial: next bit shifted on each clock rise, channels 1-4 on a, 5-8 on b
            if (!pins.cs_n && sclk_rise && st_ff.ser_oe) begin // R22
                if (st_ff.bit_idx == 4'h0) begin
                    nxt_st.bit_idx = 4'(RW - 1);
                    nxt_st.word_idx = st_ff.word_idx + 4'h1;
                    nxt_st.ser_a = next_a[RW-1];
                    nxt_st.ser_b = next_b[RW-1];
                end else begin
                    nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
                    nxt_st.ser_a = cur_word[st_ff.bit_idx - 4'h1];
                    nxt_st.ser_b = cur_b[st_ff.bit_idx - 4'h1];
                end
            end
        end

        // device reset pin: aborts conversion and clears output data
        if (dev_reset) begin
            nxt_st.busy = 1'b0;                          // R17 R19
            nxt_st.conv_run = 1'b0;
            nxt_st.seen_lo = 1'b0;
            nxt_st.seen_hi = 1'b0;
            nxt_st.result = '0;                          // R19
            nxt_st.data = 16'h0000;                      // R19
            nxt_st.ser_a = 1'b0;
            nxt_st.ser_b = 1'b0;
            nxt_st.word_idx = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
            st_ff.prev <= '{cs_n: 1'b1, rd_sclk: 1'b1, trig_lo: 1'b0, trig_hi: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign o_busy = st_ff.busy;
    assign o_hold_lo = st_ff.seen_lo;
    assign o_hold_hi = st_ff.seen_hi;
    assign o_internal_ref_en = st_ff.ref_en;
    assign o_reference_pin_oe = st_ff.ref_oe;
    assign o_wide_span = st_ff.wide;
    assign o_power_mode = st_ff.pwr;
    assign o_iface_mode = st_ff.ifm;
    assign o_data = st_ff.data;
    assign o_data_oe = st_ff.data_oe;
    assign o_serial_a = st_ff.ser_a;
    assign o_serial_b = st_ff.ser_b;
    assign o_serial_oe = st_ff.ser_oe;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_busy_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R23
        $rose(st_ff.busy) |-> $past(st_ff.seen_lo || rise_lo) && $past(st_ff.seen_hi || rise_hi))
        else $error("busy rose without both triggers");
    chk_busy_len: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || rst_q[0]) // R14
        $rose(st_ff.busy) |-> st_ff.busy [*8])
        else $error("busy dropped too early");
    chk_result_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R25
        $fell(st_ff.busy) && !$past(rst_q[0]) |-> st_ff.result == $past(st_ff.sample))
        else $error("result not latched at busy fall");
    chk_reset_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R19
        rst_q[0] |=> st_ff.result == '0 && !st_ff.busy && o_data == 16'h0000)
        else $error("reset did not clear data");
    chk_bus_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R21
        o_data_oe |-> $past(!pins.cs_n && !pins.rd_sclk) && st_ff.ifm != adc_pin_pkg::IF_SERIAL)
        else $error("bus driven without cs and strobe low");
    chk_cs_tristate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R24
        cs_rise |=> !o_data_oe && !o_serial_oe)
        else $error("outputs not released at cs rise");
    chk_power_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R8
        !i_low_power_request_n && !i_input_span_select |=> o_power_mode == adc_pin_pkg::PWR_STANDBY)
        else $error("standby not entered");
    chk_iface_sel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
        !i_interface_select |=> o_iface_mode == adc_pin_pkg::IF_PARALLEL)
        else $error("parallel mode not selected");
    chk_ref_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R4
        ##1 o_internal_ref_en == $past(i_reference_select))
        else $error("reference select not followed");
endmodule : adc_pin_ctrl
`default_nettype wire

//--- core/adc_pin_pkg.sv
// shared constants and carrier types for the pin-controlled eight-channel converter
// assumes a 100 MHz reference clock; no software registers exist
package adc_pin_pkg;
    localparam int unsigned RESULT_W = 14;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned GROUP_CH = 4;
    localparam int unsigned CODES_PER_SPAN = 16384;
    // code step weights in nanovolts, printed figures times one thousand
    localparam int unsigned STEP_NV_WIDE = 1220720;
    localparam int unsigned STEP_NV_NARROW = 610360;
    localparam int unsigned CLK_NS = 10;
    // internal conversion time, a plain default
    localparam int unsigned CONV_TIME_NS = 2000;
    localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CONV_CNT_INIT = 8'h00;

    typedef enum logic [1:0] {IF_PARALLEL, IF_SERIAL, IF_BYTE} iface_e;
    typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_SHUTDOWN} power_e;

    // host select, strobe and trigger pins after synchronising
    typedef struct packed {
        logic cs_n;
        logic rd_sclk;
        logic trig_lo;
        logic trig_hi;
    } pins_s;
endpackage : adc_pin_pkg

//--- core/adc_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs are asynchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module adc_pin_sync #(
    parameter int unsigned W = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;
    sync_s st_ff;
    sync_s nxt_st;

    // stage one is read only by stage two; output moves once stages two and three agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < int'(W); i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.q;
endmodule : adc_pin_sync
`default_nettype wire

//--- verification/adc_host_model.sv
// host pin model: reset, span, power request, triggers, chip select, strobe or serial clock
// assumes the bench calls its tasks from one process; every task except sclk_cycle returns 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module adc_host_model #(
    parameter int RECOVERY_CYCLES = 100
) (
    input wire logic i_ref_clk,
    output logic o_reset,
    output logic o_span,
    output logic o_lp_n,
    output logic o_trig_lo,
    output logic o_trig_hi,
    output logic o_cs_n,
    output logic o_rd_sclk
);
    // idle: wide span, running, no trigger, deselected, strobe and serial clock parked high
    initial begin
        {o_reset, o_span, o_lp_n, o_trig_lo, o_trig_hi, o_cs_n, o_rd_sclk} = 7'h33;
    end
    ////////////////////////////////////////////////////////////////////////////
    // sampling 1 ns after the edge keeps the bench clear of the design's updates
    task automatic cycles(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : cycles
    // reset pulse, then a settling gap before any trigger may rise
    task automatic pulse_reset();
        @(posedge i_ref_clk) o_reset <= 1'b1;
        cycles(6);
        @(posedge i_ref_clk) o_reset <= 1'b0;
        cycles(8);
    endtask : pulse_reset
    // span changes need the analog front end to settle before a conversion
    task automatic set_span(input logic v);
        @(posedge i_ref_clk) o_span <= v;
        cycles(8000);
    endtask : set_span
    task automatic set_power(input logic v);
        @(posedge i_ref_clk) o_lp_n <= v;
        cycles(v ? RECOVERY_CYCLES : 2);
    endtask : set_power
    // both groups move together whenever the bench asks for a joint conversion
    task automatic trigger(input logic lo, input logic hi);
        @(posedge i_ref_clk);
        o_trig_lo <= lo;
        o_trig_hi <= hi;
        #1;
    endtask : trigger
    task automatic select(input logic lvl);
        @(posedge i_ref_clk) o_cs_n <= lvl;
        cycles(6);
    endtask : select
    task automatic strobe(input logic lvl);
        @(posedge i_ref_clk) o_rd_sclk <= lvl;
        cycles(6);
    endtask : strobe
    // one 125 ns serial clock period, low half then high half; parked high between calls
    task automatic sclk_cycle();
        o_rd_sclk = 1'b0;
        #62.5ns o_rd_sclk = 1'b1;
        #62.5ns;
    endtask : sclk_cycle
endmodule : adc_host_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the pin-controlled converter
// assumes the host model drives the trigger, reset, power and read pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [13:0] CODES [8] = '{14'h2000, 14'h1fff, 14'h0001, 14'h3fff,
        14'h0abc, 14'h3123, 14'h0000, 14'h1555};
    logic ref_clk, rst_n, reference_select, interface_select, byte_serial_select;
    logic reset, span, lp_n, trig_lo, trig_hi, cs_n, rd_sclk;
    logic [adc_pin_pkg::NUM_CH*adc_pin_pkg::RESULT_W-1:0] ch_code;
    logic busy, hold_lo, hold_hi, ref_en, ref_oe, wide, data_oe, ser_a, ser_b, ser_oe;
    logic [1:0] power_mode, iface_mode;
    logic [15:0] data;
    int bad_count;
    int n_checks;
    adc_pin_ctrl i_adc_pin_ctrl (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_reset(reset),
        .i_reference_select(reference_select), .i_input_span_select(span),
        .i_low_power_request_n(lp_n), .i_interface_select(interface_select),
        .i_byte_serial_select(byte_serial_select), .i_sample_trigger_lo_group(trig_lo),
        .i_sample_trigger_hi_group(trig_hi), .i_cs_n(cs_n), .i_read_strobe_or_serial_clock(rd_sclk),
        .i_ch_code(ch_code), .o_busy(busy), .o_hold_lo(hold_lo), .o_hold_hi(hold_hi),
        .o_internal_ref_en(ref_en), .o_reference_pin_oe(ref_oe), .o_wide_span(wide),
        .o_power_mode(power_mode), .o_iface_mode(iface_mode), .o_data(data), .o_data_oe(data_oe),
        .o_serial_a(ser_a), .o_serial_b(ser_b), .o_serial_oe(ser_oe));
    adc_host_model i_adc_host_model (.i_ref_clk(ref_clk), .o_reset(reset), .o_span(span),
        .o_lp_n(lp_n), .o_trig_lo(trig_lo), .o_trig_hi(trig_hi), .o_cs_n(cs_n), .o_rd_sclk(rd_sclk));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // bounded wait on busy; running out ends the run
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 50 && busy !== lvl; n++) i_adc_host_model.cycles(1);
        if (busy !== lvl) begin
            bad_count++;
            $display("CHECK FAILED at %0t: busy wait ran out", $time);
            complete_run();
        end
    endtask : wait_busy
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_config();
        int k;
        for (k = 0; k < 2; k++) begin
            @(posedge ref_clk) reference_select <= k[0];
            i_adc_host_model.cycles(2);
            check(ref_en, k[0]);
            check(ref_oe, k[0]);
        end
        // running wide, running narrow, standby, shutdown
        for (k = 0; k < 4; k++) begin
            i_adc_host_model.set_span(k[0] == k[1]);
            i_adc_host_model.set_power(!k[1]);
            check(wide, k[0] == k[1]);
            check(power_mode, k[1] ? (k[0] ? adc_pin_pkg::PWR_SHUTDOWN : adc_pin_pkg::PWR_STANDBY)
                : adc_pin_pkg::PWR_NORMAL);
            if (k == 2) begin
                i_adc_host_model.trigger(1'b1, 1'b1);
                i_adc_host_model.cycles(12);
                check(busy, 1'b0);
                i_adc_host_model.trigger(1'b0, 1'b0);
            end
        end
        i_adc_host_model.set_power(1'b1);
        i_adc_host_model.pulse_reset();
        $display("test_config done");
    endtask : test_config
    // one group alone holds but does not convert; edges during busy are ignored
    task automatic test_convert();
        int n;
        i_adc_host_model.trigger(1'b1, 1'b0);
        i_adc_host_model.cycles(8);
        check(hold_lo, 1'b1);
        check(hold_hi, 1'b0);
        check(busy, 1'b0);
        // lower group inputs move after its hold; the held samples must still be read back
        @(posedge ref_clk) ch_code[0 +: 4*adc_pin_pkg::RESULT_W] <= '0;
        i_adc_host_model.trigger(1'b1, 1'b1);
        wait_busy(1'b1);
        check(hold_hi, 1'b1);
        for (n = 1; n < 400; n++) begin
            if (n == 50) i_adc_host_model.trigger(1'b0, 1'b0);
            else if (n == 60) i_adc_host_model.trigger(1'b1, 1'b1);
            else i_adc_host_model.cycles(1);
            if (busy !== 1'b1) break;
        end
        check(n[15:0], 16'(adc_pin_pkg::CONV_CYCLES));
        i_adc_host_model.cycles(20);
        check(busy, 1'b0);
        i_adc_host_model.trigger(1'b0, 1'b0);
        $display("test_convert done");
    endtask : test_convert
    // parallel (select pair 01) or byte (11) read of nch channels
    task automatic read_par(input logic byte_mode, input int nch, input logic zero);
        int k;
        logic [13:0] c;
        logic [15:0] word;
        @(posedge ref_clk);
        interface_select <= byte_mode;
        byte_serial_select <= 1'b1;
        i_adc_host_model.select(1'b0);
        check(iface_mode, byte_mode ? adc_pin_pkg::IF_BYTE : adc_pin_pkg::IF_PARALLEL);
        for (k = 0; k < nch * (byte_mode + 1); k++) begin
            c = zero ? 14'h0000 : CODES[k >> byte_mode];
            word = {{2{c[13]}}, c};
            i_adc_host_model.strobe(1'b0);
            check(data_oe, 1'b1);
            if (byte_mode) check(data[7:0], k[0] ? word[15:8] : word[7:0]);
            else check(data, word);
            i_adc_host_model.strobe(1'b1);
            check(data_oe, 1'b0);
        end
        i_adc_host_model.select(1'b1);
        check(data_oe, 1'b0);
        $display("read_par done");
    endtask : read_par
    task automatic read_serial();
        int i;
        logic [13:0] wa, wb;
        @(posedge ref_clk);
        interface_select <= 1'b1;
        byte_serial_select <= 1'b0;
        i_adc_host_model.select(1'b0);
        check(iface_mode, adc_pin_pkg::IF_SERIAL);
        check(ser_oe, 1'b1);
        for (i = 0; i < 56; i++) begin
            if (i != 0) i_adc_host_model.sclk_cycle();
            wa = {wa[12:0], ser_a};
            wb = {wb[12:0], ser_b};
            if (i % 14 == 13) begin
                check(wa, CODES[i / 14]);
                check(wb, CODES[i / 14 + 4]);
            end
        end
        i_adc_host_model.select(1'b1);
        check(ser_oe, 1'b0);
        $display("read_serial done");
    endtask : read_serial
    // reset in mid-conversion aborts it and zeroes the results
    task automatic test_reset();
        i_adc_host_model.trigger(1'b1, 1'b1);
        wait_busy(1'b1);
        i_adc_host_model.cycles(20);
        i_adc_host_model.pulse_reset();
        check(busy, 1'b0);
        i_adc_host_model.trigger(1'b0, 1'b0);
        read_par(1'b0, 1, 1'b1);
        $display("test_reset done");
    endtask : test_reset
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, reference_select, interface_select, byte_serial_select} = 4'h0;
        bad_count = 0;
        n_checks = 0;
        for (int k = 0; k < 8; k++) ch_code[k*14 +: 14] = CODES[k];
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        i_adc_host_model.cycles(4);
        i_adc_host_model.pulse_reset();
        test_config();
        test_convert();
        read_par(1'b0, 8, 1'b0);
        read_par(1'b1, 8, 1'b0);
        read_serial();
        test_reset();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
